/* rtl/pinsel_pkg.sv */
// Constants, field layouts and state types of the status pin selector.
// Assumes one MCLK domain, synchronous inputs and a plain register port.
//
// Overview of operation
// - Each pin picks source by field, optional invert
// - Second pin shares serial out, tri-state after reset
// - Code 0x0C: sync data, changes on clock fall
// - Code 0x0D: async receive data, no clock
// - Code 0x0E: high while strength above threshold
// - Code 0x0F: CRC match flag, cleared entering receive
// - Codes 0x16/0x17 hard bits, 0x1D symbol tick
// - Code 0x1B: power amplifier power-down signal
// - Code 0x1C: low-noise amplifier power-down signal
// - Code 0x2F: constant zero, one when inverted
// - Codes 0x24/0x25: wake timer events zero, one
// - Code 0x29 chip ready, 0x2B oscillator settled
// - Code 0x2D: first pin drive enable, low
// - Code 0x3F: oscillator over 192, first default
package pinsel_pkg;
    // Selection codes
    localparam logic [5:0] SEL_SYNC_DATA = 6'h0C;
    localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
    localparam logic [5:0] SEL_CARRIER = 6'h0E;
    localparam logic [5:0] SEL_CRC_OK = 6'h0F;
    localparam logic [5:0] SEL_HARD_ONE = 6'h16;
    localparam logic [5:0] SEL_HARD_ZERO = 6'h17;
    localparam logic [5:0] SEL_POWER_AMP_POWERDOWN = 6'h1B;
    localparam logic [5:0] SEL_LOW_NOISE_AMP_POWERDOWN = 6'h1C;
    localparam logic [5:0] SEL_SYM_TICK = 6'h1D;
    localparam logic [5:0] SEL_WAKE_ZERO = 6'h24;
    localparam logic [5:0] SEL_WAKE_ONE = 6'h25;
    localparam logic [5:0] SEL_CHIP_READY = 6'h29;
    localparam logic [5:0] SEL_OSC_SETTLED = 6'h2B;
    localparam logic [5:0] SEL_DRIVE_EN_LOW = 6'h2D;
    localparam logic [5:0] SEL_HIGH_Z = 6'h2E;
    localparam logic [5:0] SEL_CONST_ZERO = 6'h2F;
    localparam logic [5:0] SEL_OSC_DIV = 6'h3F;
    // Pin configuration field: select in [5:0], invert at bit 6
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_INV_BIT = 6;
    localparam logic [6:0] CFG_FIRST_RST = 7'h3F;
    localparam logic [6:0] CFG_SECOND_RST = 7'h2E;
    localparam logic [6:0] CFG_THIRD_RST = 7'h29;
    localparam logic [7:0] THRESH_RST = 8'h00;
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG_FIRST = 8'h00;
    localparam logic [7:0] ADDR_CFG_SECOND = 8'h04;
    localparam logic [7:0] ADDR_CFG_THIRD = 8'h08;
    localparam logic [7:0] ADDR_THRESH = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_LIVE = 8'h1C;
    // Interrupt bit positions
    localparam int IRQ_WAKE_ZERO = 0;
    localparam int IRQ_WAKE_ONE = 1;
    localparam int IRQ_CRC_OK = 2;
    localparam int IRQ_OSC_SETTLED = 3;
    localparam int IRQ_W = 4;
    // Oscillator divider: ratio and half period in MCLK cycles
    localparam int OSC_DIV_RATIO = 192;
    localparam logic [6:0] OSC_DIV_HALF = 7'(OSC_DIV_RATIO / 2);

    typedef struct packed {
        logic [6:0] cfg_first;
        logic [6:0] cfg_second;
        logic [6:0] cfg_third;
        logic [7:0] thresh;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [IRQ_W-1:0] ev_prev;
        logic crc_ok;
        logic sync_data;
        logic ser_clk_d;
        logic [31:0] rdata;
    } main_state_t;

    typedef struct packed {
        logic pin_o;
        logic pin_oe;
    } pin_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic clk_out;
    } div_state_t;
endpackage

/* rtl/osc_divider.sv */
// Divides MCLK by a fixed even ratio into a square wave.
// Assumes MCLK is the oscillator clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module osc_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Divided clock, from a flop
    output logic clk_div
);
    pinsel_pkg::div_state_t s, next_s;

    // Toggle every half period so the duty cycle stays even
    always_comb begin
        next_s = s;
        if (s.cnt == pinsel_pkg::OSC_DIV_HALF - 7'd1) begin
            next_s.cnt = '0;
            next_s.clk_out = ~s.clk_out;
        end else begin
            next_s.cnt = s.cnt + 7'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign clk_div = s.clk_out;

    a_div_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        s.cnt != pinsel_pkg::OSC_DIV_HALF - 7'd1 |=> $stable(s.clk_out))
        else $error("divided clock toggled early");
endmodule
`default_nettype wire

/* rtl/pin_slice.sv */
// One status pin: source select, inversion and drive enable.
// Assumes a 64-entry source vector with zeros at reserved codes.
`timescale 1ns/1ps
`default_nettype none
module pin_slice (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection
    input wire logic [5:0] sel,
    input wire logic inv,
    input wire logic [63:0] src,
    // Takeover by another owner of the pin
    input wire logic alt_sel,
    input wire logic alt_o,
    input wire logic alt_oe,
    // Pin, from flops
    output logic pin_o,
    output logic pin_oe
);
    pinsel_pkg::pin_state_t s, next_s;

    // Registered so the pin never glitches during a select change
    always_comb begin
        next_s.pin_o = src[sel] ^ inv;
        next_s.pin_oe = (sel != pinsel_pkg::SEL_HIGH_Z);
        if (alt_sel) begin
            next_s.pin_o = alt_o;
            next_s.pin_oe = alt_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pin_o = s.pin_o;
    assign pin_oe = s.pin_oe;
endmodule
`default_nettype wire

/* rtl/status_pin_signal_select.sv */
// Top of the status pin selector with its register port.
// Assumes synchronous inputs from the radio core on MCLK (250 MHz);
// reserved codes read as zero at the pin before inversion.
`timescale 1ns/1ps
`default_nettype none
module status_pin_signal_select (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RDATA,
    // Receive path from the modem
    input wire logic SER_CLK,
    input wire logic SYNC_RX_BIT,
    input wire logic ASYNC_RX_BIT,
    input wire logic [7:0] SIGNAL_STRENGTH_LEVEL,
    input wire logic CRC_DONE,
    input wire logic CRC_MATCH,
    input wire logic RX_START,
    input wire logic [1:0] RECEIVE_HARD_SYMBOL,
    input wire logic RX_SYMBOL_TICK,
    // Power and timing state
    input wire logic POWER_AMP_POWERDOWN,
    input wire logic LOW_NOISE_AMP_POWERDOWN,
    input wire logic WAKE_TIMER_EVENT_ZERO,
    input wire logic WAKE_TIMER_EVENT_ONE,
    input wire logic CHIP_READY,
    input wire logic OSCILLATOR_SETTLED_FLAG,
    input wire logic TX_SERIAL_ACTIVE,
    // Serial port sharing the second pin
    input wire logic CHIP_SELECT_N,
    input wire logic SPI_SO,
    input wire logic SPI_SO_OE,
    // First status pin, two-way
    output logic STATUS_PIN_FIRST_O,
    output logic STATUS_PIN_FIRST_OE,
    input wire logic STATUS_PIN_FIRST_I,
    output logic TX_SERIAL_DATA,
    // Second and third status pins
    output logic STATUS_PIN_SECOND_O,
    output logic STATUS_PIN_SECOND_OE,
    output logic STATUS_PIN_THIRD_O,
    output logic STATUS_PIN_THIRD_OE,
    // Interrupt
    output logic IRQ
);
    pinsel_pkg::main_state_t s, next_s;
    logic [63:0] src;
    logic carrier;
    logic drive_en_low;
    logic osc_div;
    logic ser_fall;
    logic [pinsel_pkg::IRQ_W-1:0] ev_now;
    logic [pinsel_pkg::IRQ_W-1:0] ev_rise;
    logic [pinsel_pkg::IRQ_W-1:0] clr;

    ////////////////////////////////////////////////////////////////////
    // Divided oscillator clock

    osc_divider u_div (
        .clk(MCLK),
        .rst_n(RST_N),
        .clk_div(osc_div)
    );

    ////////////////////////////////////////////////////////////////////
    // Derived signals

    // Inputs are synchronous, so edges are taken straight from them
    assign ser_fall = s.ser_clk_d & ~SER_CLK;
    assign carrier = SIGNAL_STRENGTH_LEVEL > s.thresh;
    // Low while the first pin is turned round for transmit data
    assign drive_en_low = ~TX_SERIAL_ACTIVE;
    assign TX_SERIAL_DATA = STATUS_PIN_FIRST_I & TX_SERIAL_ACTIVE;

    // Event levels watched for rising edges
    always_comb begin
        ev_now = '0;
        ev_now[pinsel_pkg::IRQ_WAKE_ZERO] = WAKE_TIMER_EVENT_ZERO;
        ev_now[pinsel_pkg::IRQ_WAKE_ONE] = WAKE_TIMER_EVENT_ONE;
        ev_now[pinsel_pkg::IRQ_CRC_OK] = s.crc_ok;
        ev_now[pinsel_pkg::IRQ_OSC_SETTLED] = OSCILLATOR_SETTLED_FLAG;
    end

    assign ev_rise = ev_now & ~s.ev_prev;
    assign clr = (WR_EN && ADDR == pinsel_pkg::ADDR_IRQ_CLEAR) ?
        WDATA[pinsel_pkg::IRQ_W-1:0] : '0;

    ////////////////////////////////////////////////////////////////////
    // Source vector; reserved test codes stay zero

    always_comb begin
        src = '0;
        src[pinsel_pkg::SEL_SYNC_DATA] = s.sync_data;
        src[pinsel_pkg::SEL_ASYNC_DATA] = ASYNC_RX_BIT;
        src[pinsel_pkg::SEL_CARRIER] = carrier;
        src[pinsel_pkg::SEL_CRC_OK] = s.crc_ok;
        src[pinsel_pkg::SEL_HARD_ONE] = RECEIVE_HARD_SYMBOL[1];
        src[pinsel_pkg::SEL_HARD_ZERO] = RECEIVE_HARD_SYMBOL[0];
        src[pinsel_pkg::SEL_SYM_TICK] = RX_SYMBOL_TICK;
        src[pinsel_pkg::SEL_POWER_AMP_POWERDOWN] = POWER_AMP_POWERDOWN;
        src[pinsel_pkg::SEL_LOW_NOISE_AMP_POWERDOWN] = LOW_NOISE_AMP_POWERDOWN;
        src[pinsel_pkg::SEL_WAKE_ZERO] = WAKE_TIMER_EVENT_ZERO;
        src[pinsel_pkg::SEL_WAKE_ONE] = WAKE_TIMER_EVENT_ONE;
        src[pinsel_pkg::SEL_CHIP_READY] = CHIP_READY;
        src[pinsel_pkg::SEL_OSC_SETTLED] = OSCILLATOR_SETTLED_FLAG;
        src[pinsel_pkg::SEL_DRIVE_EN_LOW] = drive_en_low;
        src[pinsel_pkg::SEL_CONST_ZERO] = 1'b0;
        src[pinsel_pkg::SEL_OSC_DIV] = osc_div;
    end

    ////////////////////////////////////////////////////////////////////
    // Pin slices

    // First pin hands over to transmit data input while sending
    pin_slice u_first (
        .clk(MCLK),
        .rst_n(RST_N),
        .sel(s.cfg_first[5:0]),
        .inv(s.cfg_first[pinsel_pkg::CFG_INV_BIT]),
        .src(src),
        .alt_sel(TX_SERIAL_ACTIVE),
        .alt_o(1'b0),
        .alt_oe(1'b0),
        .pin_o(STATUS_PIN_FIRST_O),
        .pin_oe(STATUS_PIN_FIRST_OE)
    );

    // Second pin belongs to the serial port while selected
    pin_slice u_second (
        .clk(MCLK),
        .rst_n(RST_N),
        .sel(s.cfg_second[5:0]),
        .inv(s.cfg_second[pinsel_pkg::CFG_INV_BIT]),
        .src(src),
        .alt_sel(~CHIP_SELECT_N),
        .alt_o(SPI_SO),
        .alt_oe(SPI_SO_OE),
        .pin_o(STATUS_PIN_SECOND_O),
        .pin_oe(STATUS_PIN_SECOND_OE)
    );

    pin_slice u_third (
        .clk(MCLK),
        .rst_n(RST_N),
        .sel(s.cfg_third[5:0]),
        .inv(s.cfg_third[pinsel_pkg::CFG_INV_BIT]),
        .src(src),
        .alt_sel(1'b0),
        .alt_o(1'b0),
        .alt_oe(1'b0),
        .pin_o(STATUS_PIN_THIRD_O),
        .pin_oe(STATUS_PIN_THIRD_OE)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        next_s.ser_clk_d = SER_CLK;
        next_s.ev_prev = ev_now;
        // Host samples on the rise, so data moves on the fall
        if (ser_fall) begin
            next_s.sync_data = SYNC_RX_BIT;
        end
        // Entering receive clears the flag even with a late compare
        if (RX_START) begin
            next_s.crc_ok = 1'b0;
        end else if (CRC_DONE) begin
            next_s.crc_ok = CRC_MATCH;
        end
        // Register writes
        if (WR_EN) begin
            case (ADDR)
                pinsel_pkg::ADDR_CFG_FIRST: begin
                    next_s.cfg_first = WDATA[6:0];
                end
                pinsel_pkg::ADDR_CFG_SECOND: begin
                    next_s.cfg_second = WDATA[6:0];
                end
                pinsel_pkg::ADDR_CFG_THIRD: begin
                    next_s.cfg_third = WDATA[6:0];
                end
                pinsel_pkg::ADDR_THRESH: begin
                    next_s.thresh = WDATA[7:0];
                end
                pinsel_pkg::ADDR_IRQ_ENABLE: begin
                    next_s.irq_en = WDATA[pinsel_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear so no event is lost
        next_s.irq_stat = (s.irq_stat & ~clr) | ev_rise;
        // Read data stand for one cycle only
        next_s.rdata = '0;
        if (RD_EN) begin
            case (ADDR)
                pinsel_pkg::ADDR_CFG_FIRST: begin
                    next_s.rdata = {25'h0, s.cfg_first};
                end
                pinsel_pkg::ADDR_CFG_SECOND: begin
                    next_s.rdata = {25'h0, s.cfg_second};
                end
                pinsel_pkg::ADDR_CFG_THIRD: begin
                    next_s.rdata = {25'h0, s.cfg_third};
                end
                pinsel_pkg::ADDR_THRESH: begin
                    next_s.rdata = {24'h0, s.thresh};
                end
                pinsel_pkg::ADDR_IRQ_STATUS: begin
                    next_s.rdata = {28'h0, s.irq_stat};
                end
                pinsel_pkg::ADDR_IRQ_ENABLE: begin
                    next_s.rdata = {28'h0, s.irq_en};
                end
                pinsel_pkg::ADDR_LIVE: begin
                    next_s.rdata = {24'h0, STATUS_PIN_THIRD_O,
                        STATUS_PIN_SECOND_O, STATUS_PIN_FIRST_O,
                        osc_div, carrier, s.sync_data, 1'b0, s.crc_ok};
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s <= '0;
            s.cfg_first <= pinsel_pkg::CFG_FIRST_RST;
            s.cfg_second <= pinsel_pkg::CFG_SECOND_RST;
            s.cfg_third <= pinsel_pkg::CFG_THIRD_RST;
            s.thresh <= pinsel_pkg::THRESH_RST;
        end else begin
            s <= next_s;
        end
    end

    assign RDATA = s.rdata;
    assign IRQ = |(s.irq_stat & s.irq_en);

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    sequence seq_sync_fall;
        $fell(SER_CLK) && s.cfg_third == {1'b0, pinsel_pkg::SEL_SYNC_DATA}
            && !TX_SERIAL_ACTIVE;
    endsequence

    sequence seq_sync_hold;
        s.cfg_third == {1'b0, pinsel_pkg::SEL_SYNC_DATA}
            && !TX_SERIAL_ACTIVE;
    endsequence

    a_third_pin_mux: assert property (
        s.cfg_third == {1'b0, pinsel_pkg::SEL_CHIP_READY}
        |=> STATUS_PIN_THIRD_O == $past(CHIP_READY))
        else $error("third pin not following chip ready");

    a_second_spi_own: assert property (
        !CHIP_SELECT_N |=> STATUS_PIN_SECOND_OE == $past(SPI_SO_OE)
            && STATUS_PIN_SECOND_O == $past(SPI_SO))
        else $error("second pin not handed to serial port");

    a_sync_fall_data: assert property (
        seq_sync_fall ##1 seq_sync_hold
        |=> STATUS_PIN_THIRD_O == $past(SYNC_RX_BIT, 2))
        else $error("sync data not taken on clock fall");

    a_sync_hold_rise: assert property (
        !ser_fall && !$fell(SER_CLK) |=> $stable(s.sync_data))
        else $error("sync data changed away from clock fall");

    a_async_pass: assert property (
        s.cfg_third == {1'b0, pinsel_pkg::SEL_ASYNC_DATA}
        |=> STATUS_PIN_THIRD_O == $past(ASYNC_RX_BIT))
        else $error("async data not passed through");

    a_carrier_level: assert property (
        s.cfg_third == {1'b0, pinsel_pkg::SEL_CARRIER}
        |=> STATUS_PIN_THIRD_O ==
            ($past(SIGNAL_STRENGTH_LEVEL) > $past(s.thresh)))
        else $error("carrier sense level wrong");

    a_crc_clear: assert property (
        RX_START |=> !s.crc_ok ##1 ($past(CRC_DONE) || !s.crc_ok))
        else $error("crc flag survived receive entry");

    a_crc_match: assert property (
        CRC_DONE && !RX_START |=> s.crc_ok == $past(CRC_MATCH))
        else $error("crc flag not following compare");

    a_const_invert: assert property (
        s.cfg_third == {1'b1, pinsel_pkg::SEL_CONST_ZERO}
        |=> STATUS_PIN_THIRD_O && STATUS_PIN_THIRD_OE)
        else $error("inverted constant not high");

    a_drive_low_code: assert property (
        s.cfg_third == {1'b0, pinsel_pkg::SEL_DRIVE_EN_LOW}
        |=> STATUS_PIN_THIRD_O == !$past(TX_SERIAL_ACTIVE))
        else $error("drive enable indicator wrong");

    a_high_z_code: assert property (
        s.cfg_third[5:0] == pinsel_pkg::SEL_HIGH_Z |=> !STATUS_PIN_THIRD_OE)
        else $error("high impedance code drives the pin");

    a_irq_set_wins: assert property (
        ev_rise[pinsel_pkg::IRQ_WAKE_ZERO]
        |=> s.irq_stat[pinsel_pkg::IRQ_WAKE_ZERO] ##1 (IRQ ||
            !s.irq_en[pinsel_pkg::IRQ_WAKE_ZERO] ||
            $past(clr[pinsel_pkg::IRQ_WAKE_ZERO])))
        else $error("event lost under clear");

    a_read_one_cycle: assert property (
        !RD_EN |=> RDATA == '0)
        else $error("read data stood past its cycle");
endmodule
`default_nettype wire

/* test/host_model.sv */
// Host side model: reads sync data on the serial clock rise and
// drives transmit data into the first pin while it is turned round.
// Assumes every input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Serial receive
    input wire logic ser_clk,
    input wire logic data_pin,
    output logic [7:0] rx_byte,
    // First pin turnaround
    input wire logic first_oe,
    output logic tx_data
);
    logic ser_prev;
    // Outputs start unknown; eight bits flush the shift register
    // Sample at the edge where a rise is first seen; the pin is settled by then
    always @(posedge clk) begin
        ser_prev <= ser_clk;
        if (ser_clk && !ser_prev) begin
            rx_byte <= {rx_byte[6:0], data_pin};
        end
    end
    // Pattern changes every cycle, so a stuck wire cannot pass
    always @(posedge clk) begin
        tx_data <= first_oe ? 1'b0 : ~tx_data;
    end
endmodule
`default_nettype wire

/* test/status_pin_signal_select_test.sv */
// Self-checking bench for the status pin selector.
// Assumes the host model beside it and the pinsel package.
`timescale 1ns/1ps
`default_nettype none
module status_pin_signal_select_test;
    logic MCLK, RST_N, WR_EN, RD_EN, SER_CLK, SYNC_RX_BIT, ASYNC_RX_BIT;
    logic [7:0] ADDR, SIGNAL_STRENGTH_LEVEL, host_rx;
    logic [31:0] WDATA, RDATA;
    logic CRC_DONE, CRC_MATCH, RX_START, RX_SYMBOL_TICK, CHIP_READY;
    logic [1:0] RECEIVE_HARD_SYMBOL;
    logic POWER_AMP_POWERDOWN, LOW_NOISE_AMP_POWERDOWN, CHIP_SELECT_N;
    logic WAKE_TIMER_EVENT_ZERO, WAKE_TIMER_EVENT_ONE, SPI_SO, SPI_SO_OE;
    logic OSCILLATOR_SETTLED_FLAG, TX_SERIAL_ACTIVE, TX_SERIAL_DATA, IRQ;
    logic STATUS_PIN_FIRST_O, STATUS_PIN_FIRST_OE, first_wire, host_tx;
    logic STATUS_PIN_SECOND_O, STATUS_PIN_SECOND_OE;
    logic STATUS_PIN_THIRD_O, STATUS_PIN_THIRD_OE;
    logic [5:0] codes [12] = '{6'h0D, 6'h0E, 6'h16, 6'h17, 6'h1B, 6'h1C,
        6'h1D, 6'h24, 6'h25, 6'h29, 6'h2B, 6'h2F};
    int num_errors, checks_done, n;

    // First pin wire: the design when driving, else the host
    assign first_wire = STATUS_PIN_FIRST_OE ? STATUS_PIN_FIRST_O : host_tx;

    status_pin_signal_select DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
        .SER_CLK(SER_CLK), .SYNC_RX_BIT(SYNC_RX_BIT),
        .ASYNC_RX_BIT(ASYNC_RX_BIT),
        .SIGNAL_STRENGTH_LEVEL(SIGNAL_STRENGTH_LEVEL),
        .CRC_DONE(CRC_DONE), .CRC_MATCH(CRC_MATCH), .RX_START(RX_START),
        .RECEIVE_HARD_SYMBOL(RECEIVE_HARD_SYMBOL),
        .RX_SYMBOL_TICK(RX_SYMBOL_TICK),
        .POWER_AMP_POWERDOWN(POWER_AMP_POWERDOWN),
        .LOW_NOISE_AMP_POWERDOWN(LOW_NOISE_AMP_POWERDOWN),
        .WAKE_TIMER_EVENT_ZERO(WAKE_TIMER_EVENT_ZERO),
        .WAKE_TIMER_EVENT_ONE(WAKE_TIMER_EVENT_ONE),
        .CHIP_READY(CHIP_READY),
        .OSCILLATOR_SETTLED_FLAG(OSCILLATOR_SETTLED_FLAG),
        .TX_SERIAL_ACTIVE(TX_SERIAL_ACTIVE), .CHIP_SELECT_N(CHIP_SELECT_N),
        .SPI_SO(SPI_SO), .SPI_SO_OE(SPI_SO_OE),
        .STATUS_PIN_FIRST_O(STATUS_PIN_FIRST_O),
        .STATUS_PIN_FIRST_OE(STATUS_PIN_FIRST_OE),
        .STATUS_PIN_FIRST_I(first_wire), .TX_SERIAL_DATA(TX_SERIAL_DATA),
        .STATUS_PIN_SECOND_O(STATUS_PIN_SECOND_O),
        .STATUS_PIN_SECOND_OE(STATUS_PIN_SECOND_OE),
        .STATUS_PIN_THIRD_O(STATUS_PIN_THIRD_O),
        .STATUS_PIN_THIRD_OE(STATUS_PIN_THIRD_OE), .IRQ(IRQ));

    host_model HOST (.clk(MCLK), .ser_clk(SER_CLK),
        .data_pin(STATUS_PIN_THIRD_O), .rx_byte(host_rx),
        .first_oe(STATUS_PIN_FIRST_OE), .tx_data(host_tx));

    // 250 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge MCLK);
        WR_EN <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge MCLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1 chk(RDATA, exp);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge MCLK);
        #1;
    endtask
    task automatic set_src(input logic [5:0] c, input logic v);
        @(posedge MCLK);
        case (c)
            6'h0D: ASYNC_RX_BIT <= v;
            6'h0E: SIGNAL_STRENGTH_LEVEL <= {7'h00, v};
            6'h16: RECEIVE_HARD_SYMBOL[1] <= v;
            6'h17: RECEIVE_HARD_SYMBOL[0] <= v;
            6'h1B: POWER_AMP_POWERDOWN <= v;
            6'h1C: LOW_NOISE_AMP_POWERDOWN <= v;
            6'h1D: RX_SYMBOL_TICK <= v;
            6'h24: WAKE_TIMER_EVENT_ZERO <= v;
            6'h25: WAKE_TIMER_EVENT_ONE <= v;
            6'h29: CHIP_READY <= v;
            6'h2B: OSCILLATOR_SETTLED_FLAG <= v;
            default: ;
        endcase
    endtask
    task automatic summarize;
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog, well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge MCLK);
        num_errors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {RST_N, WR_EN, RD_EN, SYNC_RX_BIT, ASYNC_RX_BIT, CRC_DONE} = '0;
        {CRC_MATCH, RX_START, RX_SYMBOL_TICK, CHIP_READY, SPI_SO} = '0;
        {POWER_AMP_POWERDOWN, LOW_NOISE_AMP_POWERDOWN, SPI_SO_OE} = '0;
        {WAKE_TIMER_EVENT_ZERO, WAKE_TIMER_EVENT_ONE, TX_SERIAL_ACTIVE} = '0;
        OSCILLATOR_SETTLED_FLAG = 1'b0;
        {SER_CLK, CHIP_SELECT_N} = 2'h3;
        {ADDR, SIGNAL_STRENGTH_LEVEL, RECEIVE_HARD_SYMBOL} = '0;
        WDATA = 32'h0;
        {num_errors, checks_done} = '0;
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        settle(2);
        chk(32'(STATUS_PIN_SECOND_OE), 32'h0);
        chk(32'(STATUS_PIN_FIRST_OE), 32'h1);
        // Divided clock: high half lasts half the ratio
        n = 0;
        while (STATUS_PIN_FIRST_O !== 1'b1 && n < 400) begin
            settle(1);
            n++;
        end
        n = 0;
        while (STATUS_PIN_FIRST_O === 1'b1 && n < 400) begin
            settle(1);
            n++;
        end
        chk(32'(n), 32'(pinsel_pkg::OSC_DIV_RATIO / 2));
        rd(pinsel_pkg::ADDR_LIVE, 32'h0);
        rd(pinsel_pkg::ADDR_CFG_FIRST, 32'h3F);
        rd(pinsel_pkg::ADDR_CFG_SECOND, 32'h2E);
        rd(pinsel_pkg::ADDR_CFG_THIRD, 32'h29);
        rd(pinsel_pkg::ADDR_THRESH, 32'h0);
        rd(8'h20, 32'h0);
        rd(pinsel_pkg::ADDR_IRQ_CLEAR, 32'h0);
        // Eleven directly driven sources and the constant zero through the third pin, plain and inverted
        for (int inv = 0; inv < 2; inv++) begin
            foreach (codes[i]) begin
                wr(pinsel_pkg::ADDR_CFG_THIRD, {25'h0, inv[0], codes[i]});
                for (int v = 0; v < 2; v++) begin
                    set_src(codes[i], v[0]);
                    settle(3);
                    chk(32'(STATUS_PIN_THIRD_O), 32'((codes[i] == 6'h2F) ?
                        inv[0] : v[0] ^ inv[0]));
                    chk(32'(STATUS_PIN_THIRD_OE), 32'h1);
                end
            end
        end
        // Carrier just at and just above the threshold
        wr(pinsel_pkg::ADDR_THRESH, 32'h40);
        wr(pinsel_pkg::ADDR_CFG_THIRD, 32'h0E);
        for (n = 0; n < 2; n++) begin
            @(posedge MCLK);
            SIGNAL_STRENGTH_LEVEL <= 8'h40 + 8'(n);
            settle(3);
            chk(32'(STATUS_PIN_THIRD_O), 32'(n));
        end
        // Sync byte, MSB first, bit set up at the serial clock fall
        wr(pinsel_pkg::ADDR_CFG_THIRD, 32'h0C);
        for (n = 7; n >= 0; n--) begin
            @(posedge MCLK);
            SYNC_RX_BIT <= 1'(8'hA5 >> n);
            SER_CLK <= 1'b0;
            repeat (4) @(posedge MCLK);
            SER_CLK <= 1'b1;
            repeat (3) @(posedge MCLK);
        end
        settle(3);
        chk(32'(host_rx), 32'hA5);
        // Second pin: own selection, then the serial port takes it
        wr(pinsel_pkg::ADDR_CFG_SECOND, 32'h6F);
        settle(2);
        chk({30'h0, STATUS_PIN_SECOND_O, STATUS_PIN_SECOND_OE}, 32'h3);
        @(posedge MCLK);
        CHIP_SELECT_N <= 1'b0;
        SPI_SO_OE <= 1'b1;
        settle(2);
        chk({30'h0, STATUS_PIN_SECOND_O, STATUS_PIN_SECOND_OE}, 32'h1);
        @(posedge MCLK);
        CHIP_SELECT_N <= 1'b1;
        // High impedance
        wr(pinsel_pkg::ADDR_CFG_THIRD, 32'h2E);
        settle(2);
        chk(32'(STATUS_PIN_THIRD_OE), 32'h0);
        // First pin turned round for transmit data
        wr(pinsel_pkg::ADDR_CFG_THIRD, 32'h2D);
        for (n = 1; n >= 0; n--) begin
            @(posedge MCLK);
            TX_SERIAL_ACTIVE <= n[0];
            settle(3);
            chk(32'(STATUS_PIN_THIRD_O), 32'(!n[0]));
            chk(32'(STATUS_PIN_FIRST_OE), 32'(!n[0]));
            chk(32'(TX_SERIAL_DATA), 32'(n[0] & host_tx));
        end
        // CRC flag, its interrupt, clear on receive entry
        wr(pinsel_pkg::ADDR_IRQ_CLEAR, 32'hF);
        rd(pinsel_pkg::ADDR_IRQ_STATUS, 32'h0);
        wr(pinsel_pkg::ADDR_IRQ_ENABLE, 32'h4);
        wr(pinsel_pkg::ADDR_CFG_THIRD, 32'h0F);
        @(posedge MCLK);
        CRC_DONE <= 1'b1;
        CRC_MATCH <= 1'b1;
        @(posedge MCLK);
        CRC_DONE <= 1'b0;
        settle(3);
        chk({30'h0, STATUS_PIN_THIRD_O, IRQ}, 32'h3);
        rd(pinsel_pkg::ADDR_IRQ_STATUS, 32'h4);
        @(posedge MCLK);
        RX_START <= 1'b1;
        @(posedge MCLK);
        RX_START <= 1'b0;
        settle(3);
        chk({30'h0, STATUS_PIN_THIRD_O, IRQ}, 32'h1);
        wr(pinsel_pkg::ADDR_IRQ_CLEAR, 32'h4);
        settle(1);
        chk(32'(IRQ), 32'h0);
        // Masked wake event: status set, no interrupt
        wr(pinsel_pkg::ADDR_IRQ_ENABLE, 32'h0);
        set_src(6'h24, 1'b0);
        set_src(6'h24, 1'b1);
        settle(3);
        rd(pinsel_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk(32'(IRQ), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
